//--- rtl/crs_scan_cursor.sv
`timescale 1ns/100ps
`default_nettype none
module crs_scan_cursor
   import crs_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // indexed i/o access
   input wire crs_io_req_t io_req,
   output logic [7:0] io_rdata,
   // mode and timing from the display pipeline
   input wire logic ext_mode,
   input wire logic graphics_mode,
   input wire crs_tim_t tim,
   input wire logic [CRS_ADDR_W-1:0] row_pitch,
   // results
   output logic [CRS_ADDR_W-1:0] mem_addr,
   output logic [CRS_ADDR_W-1:0] start_addr,
   output logic [CRS_ROW_W-1:0] row_scan,
   output logic [CRS_LCMP_W-1:0] line_cmp,
   output logic [CRS_VBS_W-1:0] vblank_start,
   output logic cursor_line
);
   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [7:0] idx;
      logic [7:0] ovf;
      logic [7:0] msl;
      logic [7:0] cs;
      logic [7:0] ce;
      logic [7:0] sah;
      logic [7:0] sal;
      logic [7:0] vbs8;
      logic [7:0] lcmp8;
      logic [7:0] evbs;
      logic [7:0] esa;
      logic upd;
      logic vs_q;
      logic [CRS_ADDR_W-1:0] act;
      logic [CRS_ADDR_W-1:0] start;
      logic [CRS_ADDR_W-1:0] base;
      logic [CRS_ADDR_W-1:0] mem;
      logic [CRS_SCAN_W-1:0] scan;
      logic [CRS_ROW_W-1:0] row;
      logic dph;
      logic [2:0] pipe;
      logic cur;
      logic [CRS_LCMP_W-1:0] lcmp;
      logic [CRS_VBS_W-1:0] vbs;
      logic [7:0] rdata;
   } crs_state_t;

   crs_state_t s_r;
   crs_state_t s_nxt;
   logic hit_idx;
   logic hit_dat;
   logic upd_set;
   logic vs_rise;
   logic row_clk;
   logic raw_cur;
   logic [CRS_ADDR_W-1:0] live_addr;
   logic [CRS_ADDR_W-1:0] shadow;
   logic [CRS_SKEW_W-1:0] skew;
   logic [7:0] rd_mux;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_nxt = s_r;
      upd_set = 1'b0;
      hit_idx = (io_req.addr == CRS_PORT_IDX_MONO) || (io_req.addr == CRS_PORT_IDX_COLOR);
      hit_dat = (io_req.addr == CRS_PORT_DAT_MONO) || (io_req.addr == CRS_PORT_DAT_COLOR);

      // register writes through the index/data pair
      if (io_req.wr && hit_idx) begin
         s_nxt.idx = io_req.wdata;
      end
      if (io_req.wr && hit_dat) begin
         unique case (s_r.idx)
            CRS_IDX_OVERFLOW: s_nxt.ovf = io_req.wdata;
            CRS_IDX_MAX_SCAN: s_nxt.msl = io_req.wdata;
            CRS_IDX_CUR_START: s_nxt.cs = io_req.wdata;
            CRS_IDX_CUR_END: s_nxt.ce = io_req.wdata;
            CRS_IDX_START_HIGH: begin
               s_nxt.sah = io_req.wdata;
               upd_set = ext_mode && io_req.wdata[CRS_SAH_UPD_BIT];
            end
            CRS_IDX_START_LOW: s_nxt.sal = io_req.wdata;
            CRS_IDX_BLANK_START: s_nxt.vbs8 = io_req.wdata;
            CRS_IDX_LINE_CMP: s_nxt.lcmp8 = io_req.wdata;
            CRS_IDX_EXT_BLANK: s_nxt.evbs = io_req.wdata;
            CRS_IDX_EXT_START: s_nxt.esa = io_req.wdata;
            default: ;
         endcase
      end

      // register reads; unmapped indexes read zero
      unique case (s_r.idx)
         CRS_IDX_OVERFLOW: rd_mux = s_r.ovf;
         CRS_IDX_MAX_SCAN: rd_mux = s_r.msl;
         CRS_IDX_CUR_START: rd_mux = s_r.cs;
         CRS_IDX_CUR_END: rd_mux = s_r.ce;
         CRS_IDX_START_HIGH: rd_mux = ext_mode ? {s_r.upd, s_r.sah[6:0]} : s_r.sah;
         CRS_IDX_START_LOW: rd_mux = s_r.sal;
         CRS_IDX_BLANK_START: rd_mux = s_r.vbs8;
         CRS_IDX_LINE_CMP: rd_mux = s_r.lcmp8;
         CRS_IDX_EXT_BLANK: rd_mux = s_r.evbs;
         CRS_IDX_EXT_START: rd_mux = s_r.esa;
         default: rd_mux = CRS_REG_RST;
      endcase
      if (io_req.rd && hit_dat) begin
         s_nxt.rdata = rd_mux;
      end else if (io_req.rd && hit_idx) begin
         s_nxt.rdata = s_r.idx;
      end

      ////////////////////////////////////////////////////////////////////////
      // start address: live in standard mode, double-buffered in extended
      shadow = {s_r.esa[CRS_NIB_W-1:0], s_r.sah, s_r.sal};
      vs_rise = tim.vsync && !s_r.vs_q;
      s_nxt.vs_q = tim.vsync;
      if (ext_mode && s_r.upd && vs_rise) begin
         // relies on software having written all address bytes first
         s_nxt.act = shadow;
         s_nxt.upd = 1'b0;
      end
      if (!ext_mode) begin
         s_nxt.upd = 1'b0;
      end
      // a request landing on the transfer edge is kept for the next vsync
      if (upd_set) begin
         s_nxt.upd = 1'b1;
      end
      live_addr = ext_mode ? s_r.act : {{CRS_NIB_W{1'b0}}, s_r.sah, s_r.sal};
      s_nxt.start = live_addr;

      ////////////////////////////////////////////////////////////////////////
      // derived vertical values
      s_nxt.lcmp = {s_r.msl[CRS_MSL_LCMP9_BIT], s_r.ovf[CRS_OVF_LCMP8_BIT], s_r.lcmp8};
      if (ext_mode) begin
         s_nxt.vbs = {s_r.evbs[CRS_NIB_W-1:0], s_r.vbs8};
      end else begin
         s_nxt.vbs = {2'h0, s_r.msl[CRS_MSL_VBS9_BIT], s_r.ovf[CRS_OVF_VBS8_BIT], s_r.vbs8};
      end

      ////////////////////////////////////////////////////////////////////////
      // scan line, row scan and address counting
      row_clk = !s_r.msl[CRS_MSL_DSCAN_BIT] || s_r.dph;
      if (tim.frame) begin
         s_nxt.scan = '0;
         s_nxt.row = '0;
         s_nxt.dph = 1'b0;
         s_nxt.base = live_addr;
         s_nxt.mem = live_addr;
      end else if (tim.hline) begin
         s_nxt.scan = s_r.scan + 12'h001;
         s_nxt.dph = s_r.msl[CRS_MSL_DSCAN_BIT] ? !s_r.dph : 1'b0;
         if (row_clk) begin
            if (s_r.row == s_r.msl[CRS_ROW_W-1:0]) begin
               s_nxt.row = '0;
               s_nxt.base = s_r.base + row_pitch;
            end else begin
               s_nxt.row = s_r.row + 5'h01;
            end
         end
         // split screen: lower part restarts at frame buffer byte zero
         if (s_nxt.scan == {2'h0, s_nxt.lcmp}) begin
            s_nxt.base = '0;
            s_nxt.row = '0;
         end
         s_nxt.mem = s_nxt.base;
      end else if (tim.chr && tim.active) begin
         s_nxt.mem = s_r.mem + 20'h00001;
      end

      ////////////////////////////////////////////////////////////////////////
      // cursor line with character-clock skew
      raw_cur = !graphics_mode
         && !s_r.cs[CRS_CS_OFF_BIT]
         && (s_r.row >= s_r.cs[CRS_ROW_W-1:0])
         && (s_r.row <= s_r.ce[CRS_ROW_W-1:0]);
      if (tim.chr) begin
         s_nxt.pipe = {s_r.pipe[1:0], raw_cur};
      end
      skew = s_r.ce[CRS_CE_SKEW_LSB +: CRS_SKEW_W];
      unique case (skew)
         2'h0: s_nxt.cur = raw_cur;
         2'h1: s_nxt.cur = s_r.pipe[0];
         2'h2: s_nxt.cur = s_r.pipe[1];
         2'h3: s_nxt.cur = s_r.pipe[2];
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign io_rdata = s_r.rdata;
   assign mem_addr = s_r.mem;
   assign start_addr = s_r.start;
   assign row_scan = s_r.row;
   assign line_cmp = s_r.lcmp;
   assign vblank_start = s_r.vbs;
   assign cursor_line = s_r.cur;
endmodule
`default_nettype wire

//--- shared/crs_pkg.sv
// How it works
// - double-scan bit set halves the row scan counter clock to every second line
// - line compare is ten bits: max-scan bit 6, overflow bit 4, compare byte
// - scan line matching line compare zeroes the memory address counter
// - lines above compare show start address, lines from compare show address zero
// - standard mode blanking start: max-scan bit 5, overflow bit 3, blanking byte
// - extended mode blanking start takes its top four bits from extended register
// - max-scan bits 4-0 hold scan lines per text row minus one
// - cursor is shown only in text modes, graphics ignores cursor settings
// - cursor start bit 5 set hides the cursor
// - cursor start bits 4-0 give the first cursor line, counted from zero
// - cursor end bits 4-0 give the last cursor line, counted from zero
// - cursor end bits 6-5 delay the cursor by zero to three character clocks
// - standard mode start address is sixteen bits from high and low registers
// - extended mode start address adds bits 19-16 from extended start register
// - extended start address moves to the active copy at vsync after flag set
// - the update flag clears once the transfer has happened
// - registers are reached through the data port after writing the index port
`default_nettype none
package crs_pkg;
   ////////////////////////////////////////////////////////////////////////////
   localparam logic [15:0] CRS_PORT_IDX_MONO = 16'h03b4;
   localparam logic [15:0] CRS_PORT_DAT_MONO = 16'h03b5;
   localparam logic [15:0] CRS_PORT_IDX_COLOR = 16'h03d4;
   localparam logic [15:0] CRS_PORT_DAT_COLOR = 16'h03d5;
   localparam logic [7:0] CRS_IDX_OVERFLOW = 8'h07;
   localparam logic [7:0] CRS_IDX_MAX_SCAN = 8'h09;
   localparam logic [7:0] CRS_IDX_CUR_START = 8'h0a;
   localparam logic [7:0] CRS_IDX_CUR_END = 8'h0b;
   localparam logic [7:0] CRS_IDX_START_HIGH = 8'h0c;
   localparam logic [7:0] CRS_IDX_START_LOW = 8'h0d;
   localparam logic [7:0] CRS_IDX_BLANK_START = 8'h15;
   localparam logic [7:0] CRS_IDX_LINE_CMP = 8'h18;
   localparam logic [7:0] CRS_IDX_EXT_BLANK = 8'h33;
   localparam logic [7:0] CRS_IDX_EXT_START = 8'h40;
   ////////////////////////////////////////////////////////////////////////////
   localparam int CRS_MSL_DSCAN_BIT = 7;
   localparam int CRS_MSL_LCMP9_BIT = 6;
   localparam int CRS_MSL_VBS9_BIT = 5;
   localparam int CRS_OVF_LCMP8_BIT = 4;
   localparam int CRS_OVF_VBS8_BIT = 3;
   localparam int CRS_CS_OFF_BIT = 5;
   localparam int CRS_SAH_UPD_BIT = 7;
   localparam int CRS_CE_SKEW_LSB = 5;
   localparam int CRS_ROW_W = 5;
   localparam int CRS_SKEW_W = 2;
   localparam int CRS_NIB_W = 4;
   localparam int CRS_LCMP_W = 10;
   localparam int CRS_VBS_W = 12;
   localparam int CRS_ADDR_W = 20;
   localparam int CRS_SCAN_W = 12;
   localparam logic [7:0] CRS_REG_RST = 8'h00;
   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [7:0] wdata;
   } crs_io_req_t;

   typedef struct packed {
      logic frame;
      logic hline;
      logic chr;
      logic active;
      logic vsync;
   } crs_tim_t;
endpackage
`default_nettype wire

//--- tb/crs_scan_cursor_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module crs_scan_cursor_assertions
   import crs_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // bus, modes, timing
   input wire crs_io_req_t io_req,
   input wire logic [7:0] io_rdata,
   input wire logic ext_mode,
   input wire logic graphics_mode,
   input wire crs_tim_t tim,
   input wire logic [19:0] row_pitch,
   // results
   input wire logic [19:0] mem_addr,
   input wire logic [19:0] start_addr,
   input wire logic [4:0] row_scan,
   input wire logic [9:0] line_cmp,
   input wire logic [11:0] vblank_start,
   input wire logic cursor_line
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////
   property p_frame; tim.frame && !tim.hline |=> row_scan == 5'h0; endproperty
   a_frame: assert property (p_frame) else $error("row scan not cleared at frame");
   property p_chr; tim.chr && tim.active && !tim.hline && !tim.frame |=> mem_addr == $past(mem_addr) + 20'h1; endproperty
   a_chr: assert property (p_chr) else $error("address not stepped");
   property p_mhold; !tim.chr && !tim.hline && !tim.frame |=> $stable(mem_addr); endproperty
   a_mhold: assert property (p_mhold) else $error("address moved idle");
   property p_rhold; !tim.hline && !tim.frame |=> $stable(row_scan); endproperty
   a_rhold: assert property (p_rhold) else $error("row scan moved without line");
   property p_rdata; !io_req.rd |=> $stable(io_rdata); endproperty
   a_rdata: assert property (p_rdata) else $error("read data moved");
   property p_std; !ext_mode |=> start_addr[19:16] == 4'h0; endproperty
   a_std: assert property (p_std) else $error("start address wide in std");
   property p_vbs; !ext_mode |=> vblank_start[11:10] == 2'h0; endproperty
   a_vbs: assert property (p_vbs) else $error("blank start wide in std");
   // a vsync rise one edge back still lands in start_addr
   property p_xhold; ext_mode && $past(ext_mode) && !($past(tim.vsync) && !$past(tim.vsync, 2)) |=> $stable(start_addr); endproperty
   a_xhold: assert property (p_xhold) else $error("start moved without vsync");
   c_vs: cover property (ext_mode && tim.vsync);
   c_cur: cover property ($rose(cursor_line));
   c_gfx: cover property (graphics_mode && tim.hline);
endmodule
bind crs_scan_cursor crs_scan_cursor_assertions i_chk (.*);
`default_nettype wire

//--- tb/crs_scan_cursor_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module crs_scan_cursor_tb_top;
   import crs_pkg::*;
   logic clk, rst, ext_mode, graphics_mode, cursor_line, cx, cp;
   crs_io_req_t io_req;
   crs_tim_t tim;
   logic [7:0] io_rdata, rv;
   logic [19:0] row_pitch, mem_addr, start_addr, st;
   logic [4:0] row_scan;
   logic [9:0] line_cmp;
   logic [11:0] vblank_start;
   logic [7:0] m [256];
   int fail_count, tests_run, k, p, n, ms, s, e, j, r;
   localparam logic [7:0] IX [10] = '{8'h07, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h15, 8'h18, 8'h33, 8'h40};
   crs_scan_cursor i_dut (.*);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim;
      if (fail_count == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      io_req = '{wr: w, rd: !w, addr: a, wdata: d};
      @(negedge clk);
      io_req = '0;
   endtask
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      io(1'b1, CRS_PORT_IDX_COLOR, i);
      io(1'b1, CRS_PORT_DAT_COLOR, d);
      m[i] = d;
   endtask
   // mono pair for reads so both decodes get used
   task automatic rd(input logic [7:0] i);
      io(1'b1, CRS_PORT_IDX_MONO, i);
      io(1'b0, CRS_PORT_DAT_MONO, 8'h00);
      rv = io_rdata;
   endtask
   task automatic pulse(input int b);
      @(negedge clk);
      tim[b] = 1'b1;
      @(negedge clk);
      tim[b] = 1'b0;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      fail_count = 0;
      tests_run = 0;
      rst = 1'b1;
      ext_mode = 1'b0;
      graphics_mode = 1'b0;
      io_req = '0;
      tim = 5'h02;
      row_pitch = 20'h0;
      k = $urandom(38);
      repeat (5) @(negedge clk);
      rst = 1'b0;
      for (k = 0; k < 10; k++) begin
         wr(IX[k], 8'($urandom));
         rd(IX[k]);
         chk("reg", rv, m[IX[k]]);
      end
      wr(8'h08, 8'h5a);
      rd(8'h08);
      chk("unmapped", rv, 8'h00);
      chk("lcmp", line_cmp, {m[8'h09][6], m[8'h07][4], m[8'h18]});
      chk("vbs", vblank_start, {m[8'h09][5], m[8'h07][3], m[8'h15]});
      chk("start", start_addr, {m[8'h0c], m[8'h0d]});
      ext_mode = 1'b1;
      repeat (2) @(negedge clk);
      chk("vbs_x", vblank_start, {m[8'h33][3:0], m[8'h15]});
      // third pass leaves the flag clear, so vsync must not load
      for (j = 0; j < 3; j++) begin
         wr(8'h40, 8'($urandom));
         wr(8'h0d, 8'($urandom));
         if (j < 2) wr(8'h0c, 8'($urandom) | 8'h80);
         rd(8'h0c);
         chk("flag", rv[7], j < 2);
         if (j > 0) chk("hold", start_addr, st);
         pulse(0);
         @(negedge clk);
         if (j < 2) st = {m[8'h40][3:0], m[8'h0c], m[8'h0d]};
         chk("xfer", start_addr, st);
         rd(8'h0c);
         chk("clr", rv, {1'b0, m[8'h0c][6:0]});
      end
      ext_mode = 1'b0;
      wr(8'h0c, 8'($urandom) & 8'h7f);
      wr(8'h07, 8'h00);
      wr(8'h18, 8'h0c);
      st = {m[8'h0c], m[8'h0d]};
      for (p = 0; p < 4; p++) begin
         ms = $urandom % 3 + 1;
         n = $urandom % 4;
         s = $urandom % (ms + 1);
         e = s + $urandom % (ms + 1 - s);
         row_pitch = 20'($urandom);
         graphics_mode = p == 1;
         wr(8'h09, {p == 3, 2'b00, 5'(ms)});
         wr(8'h0a, {2'b00, p == 2, 5'(s)});
         wr(8'h0b, {1'b0, 2'(n), 5'(e)});
         pulse(4);
         for (k = 1; k < 15; k++) begin
            pulse(3);
            @(negedge clk);
            j = k < 12 ? (p == 3 ? k / 2 : k) : k - 12;
            r = j % (ms + 1);
            if (p < 3 || (k % 2 == 0 && k < 12)) begin
               chk("row", row_scan, r);
               chk("mem", mem_addr, (k < 12 ? st : 0) + j / (ms + 1) * row_pitch);
            end
            cx = p == 0 && r >= s && r <= e;
            if (p < 3 && k > 1 && n > 0) chk("skew", cursor_line, cp);
            repeat (3) pulse(2);
            @(negedge clk);
            if (p < 3) chk("cur", cursor_line, cx);
            cp = cx;
         end
      end
      end_sim;
   end
endmodule
`default_nettype wire
